// ===== hw/clock_buffer_smbus_regs.sv
// smbus target register bank of a six-output clock fanout buffer
// assumes: scl is the host's clock, sda open drain resolved outside,
// straps stable across reset release, clk free running
`default_nettype none

// Operation
// - block read opens with start, write address, index; both acked
// - repeated start and read address follow; device acks before data
// - first returned byte is the count from the read-count register
// - then registers from index upward, one per byte, count bytes
// - enable bit 1 lets output follow its low pin; 0 forces low
// - register 1 top bits report loop mode latched from the strap
// - override bit picks latched mode or written mode bits
// - amplitude field in register 1 bits 1:0, default 10
// - per-output slew bits in register 2, 1 fast, default fast
// - register 3 bit 0 sets feedback edge rate, default fast
// - frequency bits act only while register 3 bit 5 is set
// - register 4 always reads all ones
// - register 5 reads fixed revision and maker codes
// - register 6 reads fixed category and device codes
// - read-count field in register 7 bits 4:0, default eight
// - block write: address, index, count, data bytes, each acked
module clock_buffer_smbus_regs #(
  parameter logic [3:0] silicon_revision_field = 4'h3, // arbitrary value
  parameter logic [3:0] maker_code_field       = 4'h5, // arbitrary value
  parameter logic [1:0] device_category        = 2'h2, // arbitrary value
  parameter logic [5:0] device_identifier      = 6'h2a // arbitrary value
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [5:0] output_enable_n,
  input  wire logic [1:0] loop_mode_strap,
  input  wire logic [1:0] address_strap,
  output logic      [5:0] clock_output_pair_run,
  output logic      [5:0] edge_rate_select,
  output logic            feedback_edge_rate_select,
  output logic      [1:0] amplitude,
  output logic      [1:0] loop_mode,
  output logic            freq_select_active,
  output logic      [1:0] freq_choice_bits
);

  // ==========================================================================
  // decoding helpers
  function automatic logic [5:0] pick_outputs(input logic [7:0] b);
    return {b[7], b[6], b[4], b[3], b[2], b[0]};
  endfunction

  function automatic logic [7:0] read_reg(
    input logic [7:0]         idx,
    input cfg_pkg::reg_bank_t bank,
    input logic [1:0]         readback
  );
    logic [7:0] v;
    v = 8'h00;
    if (idx[7:3] == 5'h00) begin
      v = (bank[idx[2:0]] & cfg_pkg::reg_write_mask[idx[2:0]])
        | cfg_pkg::reg_fixed_ones[idx[2:0]];
      if (idx[2:0] == cfg_pkg::pll_mode_and_amplitude) begin
        v[7:6] = readback;
      end
      if (idx[2:0] == cfg_pkg::revision_vendor_code) begin
        v = {silicon_revision_field, maker_code_field};
      end
      if (idx[2:0] == cfg_pkg::device_category_code) begin
        v = {device_category, device_identifier};
      end
    end
    return v;
  endfunction

  function automatic logic [6:0] addr_of(input logic [1:0] strap);
    logic [6:0] a;
    a = cfg_pkg::target_addr_strap_high;
    if (strap == 2'h0) begin
      a = cfg_pkg::target_addr_strap_low;
    end else if (strap == 2'h1) begin
      a = cfg_pkg::target_addr_strap_mid;
    end
    return a;
  endfunction

  // ==========================================================================
  // state types
  typedef struct packed {
    cfg_pkg::link_state_t state;
    logic [2:0]           bit_cnt;
    logic [7:0]           shift;
    logic [7:0]           tx;
    logic [7:0]           ptr;
    logic [7:0]           remain;
    logic                 rd;
    logic                 oe;
    logic                 start_seen;
    logic                 cfg_req;
    logic                 taken_s1;
    logic                 taken_s2;
    cfg_pkg::reg_bank_t   bank;
  } link_t;

  typedef struct packed {
    logic [5:0]      oe_n_s1;
    logic [5:0]      oe_n_s2;
    logic [3:0]      strap_s1;
    logic [3:0]      strap_s2;
    logic [1:0]      settle;
    logic            taken;
    logic [1:0]      latched_mode;
    logic [6:0]      my_addr;
    logic            req_s1;
    logic            req_s2;
    logic            req_seen;
    logic [3:0][7:0] cfg;
    logic [5:0]      run;
    logic [5:0]      slew;
    logic            fb_slew;
    logic [1:0]      amp;
    logic [1:0]      mode;
    logic            fsel_act;
    logic [1:0]      fsel;
  } core_t;

  link_t l;
  link_t next_l;
  core_t c;
  core_t next_c;
  logic  start_tog;

  // ==========================================================================
  // start detect: sda falling while scl high
  // start hold time keeps this stable at the following scl fall
  always_ff @(negedge sda_in or negedge reset_n) begin
    if (!reset_n) begin
      start_tog <= 1'b0;
    end else if (scl) begin
      start_tog <= ~start_tog;
    end
  end

  // ==========================================================================
  // link logic, all on the falling scl edge: sda of the high phase just
  // ended is sampled and the drive for the next bit is set together
  logic       start;
  logic [7:0] byte_in;
  logic       byte_done;
  logic       addr_hit;
  logic [7:0] rd_val;

  always_comb begin
    start     = start_tog != l.start_seen;
    byte_in   = {l.shift[6:0], sda_in};
    byte_done = l.bit_cnt == cfg_pkg::last_bit;
    addr_hit  = l.taken_s2 && (byte_in[7:1] == c.my_addr);
    rd_val    = read_reg(l.ptr, l.bank, c.latched_mode);
    next_l    = l;
    next_l.taken_s1 = c.taken;
    next_l.taken_s2 = l.taken_s1;
    unique case (l.state)
      cfg_pkg::st_idle: begin
        next_l.oe = 1'b0;
      end
      cfg_pkg::st_addr: begin
        next_l.shift   = byte_in;
        next_l.bit_cnt = l.bit_cnt + 3'h1;
        if (byte_done) begin
          if (addr_hit) begin
            next_l.oe    = 1'b1;
            next_l.rd    = byte_in[0];
            next_l.state = cfg_pkg::st_addr_ack;
          end else begin
            next_l.state = cfg_pkg::st_idle;
          end
        end
      end
      cfg_pkg::st_addr_ack: begin
        if (l.rd) begin
          // count byte first, its msb goes out at once
          next_l.tx = {3'h0, l.bank[cfg_pkg::read_byte_count]
                              [cfg_pkg::read_count_msb:0]};
          next_l.remain = {3'h0, l.bank[cfg_pkg::read_byte_count]
                                  [cfg_pkg::read_count_msb:0]};
          next_l.oe    = ~next_l.tx[7];
          next_l.state = cfg_pkg::st_tx;
        end else begin
          next_l.oe    = 1'b0;
          next_l.state = cfg_pkg::st_index;
        end
      end
      cfg_pkg::st_index: begin
        next_l.shift   = byte_in;
        next_l.bit_cnt = l.bit_cnt + 3'h1;
        if (byte_done) begin
          next_l.ptr   = byte_in;
          next_l.oe    = 1'b1;
          next_l.state = cfg_pkg::st_index_ack;
        end
      end
      cfg_pkg::st_index_ack: begin
        // a repeated start from here turns this into a read
        next_l.oe    = 1'b0;
        next_l.state = cfg_pkg::st_wcount;
      end
      cfg_pkg::st_wcount: begin
        next_l.shift   = byte_in;
        next_l.bit_cnt = l.bit_cnt + 3'h1;
        if (byte_done) begin
          next_l.remain = byte_in;
          next_l.oe     = 1'b1;
          next_l.state  = cfg_pkg::st_wcount_ack;
        end
      end
      cfg_pkg::st_wcount_ack: begin
        next_l.oe    = 1'b0;
        next_l.state = cfg_pkg::st_wdata;
      end
      cfg_pkg::st_wdata: begin
        next_l.shift   = byte_in;
        next_l.bit_cnt = l.bit_cnt + 3'h1;
        if (byte_done) begin
          if (l.remain != 8'h00) begin
            if (l.ptr[7:3] == 5'h00) begin
              next_l.bank[l.ptr[2:0]] = byte_in
                & cfg_pkg::reg_write_mask[l.ptr[2:0]];
            end
            next_l.cfg_req = ~l.cfg_req;
            next_l.ptr     = l.ptr + 8'h01;
            next_l.remain  = l.remain - 8'h01;
            next_l.oe      = 1'b1;
            next_l.state   = cfg_pkg::st_wdata_ack;
          end else begin
            // bytes past the count are not acked
            next_l.state = cfg_pkg::st_idle;
          end
        end
      end
      cfg_pkg::st_wdata_ack: begin
        next_l.oe    = 1'b0;
        next_l.state = cfg_pkg::st_wdata;
      end
      cfg_pkg::st_tx: begin
        next_l.bit_cnt = l.bit_cnt + 3'h1;
        if (byte_done) begin
          next_l.oe    = 1'b0;
          next_l.state = cfg_pkg::st_tx_ack;
        end else begin
          next_l.tx = {l.tx[6:0], 1'b0};
          next_l.oe = ~l.tx[6];
        end
      end
      cfg_pkg::st_tx_ack: begin
        if (!sda_in && l.remain != 8'h00) begin
          next_l.tx     = rd_val;
          next_l.ptr    = l.ptr + 8'h01;
          next_l.remain = l.remain - 8'h01;
          next_l.oe     = ~rd_val[7];
          next_l.state  = cfg_pkg::st_tx;
        end else begin
          next_l.oe    = 1'b0;
          next_l.state = cfg_pkg::st_idle;
        end
      end
      default: begin
        next_l.oe    = 1'b0;
        next_l.state = cfg_pkg::st_idle;
      end
    endcase
    if (start) begin
      // a start, first or repeated, always restarts address reception
      next_l.start_seen = start_tog;
      next_l.bit_cnt    = 3'h0;
      next_l.oe         = 1'b0;
      next_l.state      = cfg_pkg::st_addr;
    end
  end

  always_ff @(negedge scl or negedge reset_n) begin
    if (!reset_n) begin
      l <= '{state: cfg_pkg::st_idle, bank: cfg_pkg::reg_reset,
             default: '0};
    end else begin
      l <= next_l;
    end
  end

  // ==========================================================================
  // core logic on clk: straps, pin sync, config handover, outputs
  always_comb begin
    next_c          = c;
    next_c.oe_n_s1  = output_enable_n;
    next_c.oe_n_s2  = c.oe_n_s1;
    next_c.strap_s1 = {loop_mode_strap, address_strap};
    next_c.strap_s2 = c.strap_s1;
    if (!c.taken) begin
      if (c.settle == cfg_pkg::strap_settle_cycles) begin
        next_c.taken        = 1'b1;
        next_c.latched_mode = c.strap_s2[3:2];
        next_c.my_addr      = addr_of(c.strap_s2[1:0]);
      end else begin
        next_c.settle = c.settle + 2'h1;
      end
    end
    next_c.req_s1 = l.cfg_req;
    next_c.req_s2 = c.req_s1;
    if (c.req_s2 != c.req_seen) begin
      // a torn copy is repaired by the toggle of the next write
      next_c.req_seen = c.req_s2;
      next_c.cfg      = l.bank[3:0];
    end
    next_c.run = pick_outputs(c.cfg[cfg_pkg::output_enable_ctrl])
               & ~c.oe_n_s2;
    next_c.slew = pick_outputs(c.cfg[cfg_pkg::output_slew_ctrl]);
    next_c.fb_slew = c.cfg[cfg_pkg::freq_select_ctrl]
                          [cfg_pkg::feedback_slew_bit];
    next_c.amp = c.cfg[cfg_pkg::pll_mode_and_amplitude]
                      [cfg_pkg::amplitude_lsb +: 2];
    next_c.mode = c.latched_mode;
    if (c.cfg[cfg_pkg::pll_mode_and_amplitude]
             [cfg_pkg::mode_override_bit]) begin
      next_c.mode = c.cfg[cfg_pkg::pll_mode_and_amplitude]
                         [cfg_pkg::mode_bits_lsb +: 2];
    end
    next_c.fsel_act = c.cfg[cfg_pkg::freq_select_ctrl]
                           [cfg_pkg::freq_enable_bit];
    next_c.fsel = 2'h0;
    if (next_c.fsel_act) begin
      next_c.fsel = c.cfg[cfg_pkg::freq_select_ctrl]
                         [cfg_pkg::freq_bits_lsb +: 2];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      c <= '{cfg: cfg_pkg::reg_reset[3:0], default: '0};
    end else begin
      c <= next_c;
    end
  end

  // ==========================================================================
  // outputs
  assign sda_out                   = 1'b0; // open drain, only pulls low
  assign sda_oe                    = l.oe;
  assign clock_output_pair_run     = c.run;
  assign edge_rate_select          = c.slew;
  assign feedback_edge_rate_select = c.fb_slew;
  assign amplitude                 = c.amp;
  assign loop_mode                 = c.mode;
  assign freq_select_active        = c.fsel_act;
  assign freq_choice_bits          = c.fsel;

  // ==========================================================================
  // checks
  addr_ack_a: assert property (@(negedge scl) disable iff (!reset_n)
    (l.state == cfg_pkg::st_addr && byte_done && addr_hit && !start)
    |=> (l.state == cfg_pkg::st_addr_ack && sda_oe))
    else $error("matching address not acknowledged");

  foreign_addr_a: assert property (@(negedge scl)
    disable iff (!reset_n)
    (l.state == cfg_pkg::st_addr && byte_done && !addr_hit && !start)
    |=> (l.state == cfg_pkg::st_idle && !sda_oe))
    else $error("foreign address answered");

  count_byte_a: assert property (@(negedge scl)
    disable iff (!reset_n)
    (l.state == cfg_pkg::st_addr_ack && l.rd && !start)
    |=> (l.tx == {3'h0, $past(l.bank[7][4:0])}
         && sda_oe == ~l.tx[7]))
    else $error("count byte not loaded from read-count register");

  tx_bits_a: assert property (@(negedge scl) disable iff (!reset_n)
    (l.state == cfg_pkg::st_tx && !byte_done && !start)
    |=> (sda_oe == ~$past(l.tx[6])))
    else $error("transmitted bit wrong");

  host_ack_a: assert property (@(negedge scl) disable iff (!reset_n)
    (l.state == cfg_pkg::st_tx_ack && !sda_in && l.remain != 8'h00
     && !start)
    |=> (l.state == cfg_pkg::st_tx && l.ptr == $past(l.ptr) + 8'h01))
    else $error("acked read did not advance");

  nack_end_a: assert property (@(negedge scl) disable iff (!reset_n)
    (l.state == cfg_pkg::st_tx_ack && sda_in && !start)
    |=> (l.state == cfg_pkg::st_idle && !sda_oe))
    else $error("not-acknowledge did not end the read");

  rsvd_read_a: assert property (@(negedge scl) disable iff (!reset_n)
    (l.state == cfg_pkg::st_tx_ack && !sda_in && l.remain != 8'h00
     && l.ptr == 8'h04 && !start)
    |=> (l.tx == 8'hff))
    else $error("reserved register not all ones");

  write_end_a: assert property (@(negedge scl) disable iff (!reset_n)
    (l.state == cfg_pkg::st_wdata && byte_done && l.remain == 8'h00
     && !start)
    |=> (l.state == cfg_pkg::st_idle && !sda_oe))
    else $error("byte beyond write count acknowledged");

  gate_low_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!c.cfg[0][7] || c.oe_n_s2[5]) |=> !clock_output_pair_run[5])
    else $error("disabled output still running");

  mode_src_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!c.cfg[1][5]) |=> (loop_mode == $past(c.latched_mode)))
    else $error("written mode bits used without override");

  freq_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!c.cfg[3][5]) |=> (freq_choice_bits == 2'h0 && !freq_select_active))
    else $error("frequency bits active while disabled");

  read_cov: cover property (@(negedge scl) disable iff (!reset_n)
    l.state == cfg_pkg::st_tx_ack ##1 l.state == cfg_pkg::st_tx);
  write_cov: cover property (@(negedge scl) disable iff (!reset_n)
    l.state == cfg_pkg::st_wdata_ack);
  nack_cov: cover property (@(negedge scl) disable iff (!reset_n)
    l.state == cfg_pkg::st_tx_ack && sda_in);
  cfg_cov: cover property (@(posedge clk) disable iff (!reset_n)
    c.req_s2 != c.req_seen);

endmodule

`default_nettype wire

// ===== hw/cfg_pkg.sv
// constants shared by the smbus register bank of the clock fanout buffer
// assumes: a single target on the smbus segment, byte-wide registers 0..7
`default_nettype none

package cfg_pkg;

  // ==========================================================================
  // link states, gray coded along the write path
  typedef enum logic [3:0] {
    st_idle       = 4'h0,
    st_addr       = 4'h1,
    st_addr_ack   = 4'h3,
    st_index      = 4'h2,
    st_index_ack  = 4'h6,
    st_wcount     = 4'h7,
    st_wcount_ack = 4'h5,
    st_wdata      = 4'h4,
    st_wdata_ack  = 4'hc,
    st_tx         = 4'hd,
    st_tx_ack     = 4'hf
  } link_state_t;

  typedef logic [7:0][7:0] reg_bank_t;

  // ==========================================================================
  // register offsets
  localparam logic [2:0] output_enable_ctrl     = 3'h0;
  localparam logic [2:0] pll_mode_and_amplitude = 3'h1;
  localparam logic [2:0] output_slew_ctrl       = 3'h2;
  localparam logic [2:0] freq_select_ctrl       = 3'h3;
  localparam logic [2:0] reserved_all_ones      = 3'h4;
  localparam logic [2:0] revision_vendor_code   = 3'h5;
  localparam logic [2:0] device_category_code   = 3'h6;
  localparam logic [2:0] read_byte_count        = 3'h7;

  // ==========================================================================
  // per-register layout, index 7 leftmost
  localparam reg_bank_t reg_write_mask = {
    8'h1f, 8'h00, 8'h00, 8'h00, 8'h39, 8'hdd, 8'h3b, 8'hdd};
  localparam reg_bank_t reg_reset = {
    8'h08, 8'h00, 8'h00, 8'h00, 8'h01, 8'hdd, 8'h02, 8'hdd};
  localparam reg_bank_t reg_fixed_ones = {
    8'h00, 8'h00, 8'h00, 8'hff, 8'h46, 8'h02, 8'h04, 8'h00};

  // ==========================================================================
  // field positions
  localparam int unsigned mode_readback_lsb = 6;
  localparam int unsigned mode_override_bit = 5;
  localparam int unsigned mode_bits_lsb     = 3;
  localparam int unsigned amplitude_lsb     = 0;
  localparam int unsigned freq_enable_bit   = 5;
  localparam int unsigned freq_bits_lsb     = 3;
  localparam int unsigned feedback_slew_bit = 0;
  localparam int unsigned read_count_msb    = 4;

  // ==========================================================================
  // target addresses per strap setting, and timing
  localparam logic [6:0] target_addr_strap_low  = 7'h58;
  localparam logic [6:0] target_addr_strap_mid  = 7'h59;
  localparam logic [6:0] target_addr_strap_high = 7'h5a;
  localparam logic [1:0] strap_settle_cycles    = 2'h2;
  localparam logic [2:0] last_bit               = 3'h7;

endpackage

`default_nettype wire

// ===== test/smbus_host_model.sv
// smbus host model: start, stop, byte transfers, indexed block cycles
// assumes: the bench resolves sda from both pull enables, idle high
`default_nettype none

module smbus_host_model (
  output var logic scl,
  output var logic sda_pull,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  int unsigned misses;
  logic [7:0]  rd [0:8];

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    misses = 0;
  end

  // ==========================================================================
  // bit level; sda moves mid low phase, away from the sampling fall
  task automatic bit_io(input logic b, output logic s);
    #5 sda_pull = !b;
    #10 scl = 1'b1;
    #15 s = sda;
    scl = 1'b0;
  endtask

  task automatic start_cond();
    #5 sda_pull = 1'b0;
    #10 scl = 1'b1;
    #7 sda_pull = 1'b1;
    #8 scl = 1'b0;
  endtask

  // scl is left high: the link clock stands still between frames
  task automatic stop_cond();
    #5 sda_pull = 1'b1;
    #10 scl = 1'b1;
    #7 sda_pull = 1'b0;
  endtask

  task automatic put(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    if (s) misses++;
  endtask

  task automatic get(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(!ack, s);
  endtask

  // ==========================================================================
  // block cycles
  task automatic write_block(input logic [6:0] a, input logic [7:0] idx,
                             input logic [7:0] d[$]);
    start_cond();
    put({a, 1'b0});
    put(idx);
    put(8'(d.size()));
    foreach (d[k]) put(d[k]);
    stop_cond();
  endtask

  task automatic read_block(input logic [6:0] a, input logic [7:0] idx,
                            input int n);
    start_cond();
    put({a, 1'b0});
    put(idx);
    start_cond();
    put({a, 1'b1});
    for (int k = 0; k <= n; k++) get(k < n, rd[k]);
    stop_cond();
  endtask

  task automatic probe(input logic [6:0] a);
    start_cond();
    put({a, 1'b0});
    stop_cond();
  endtask

endmodule

`default_nettype wire

// ===== test/smbus_clock_buffer_config_regs_tb_top.sv
// bench for the smbus register bank: host model on scl/sda, core checks
// assumes: package, bank and host model compiled before this file
`default_nettype none

module smbus_clock_buffer_config_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    logic [2:0]  idx;
    logic [7:0]  val;
    logic [19:0] outs;
  } row_t;

  logic        clk             = 1'b0;
  // starts high so the first reset is a real falling edge for the link flops
  logic        reset_n         = 1'b1;
  logic [5:0]  output_enable_n = 6'h00;
  logic [1:0]  loop_mode_strap = 2'h2;
  logic [1:0]  address_strap   = 2'h0;
  logic        scl;
  logic        sda_pull;
  logic        sda_oe;
  logic        sda_drive;
  logic [6:0]  target_addr     = 7'h58;
  logic [5:0]  run;
  logic [5:0]  edge_sel;
  logic        fb_edge;
  logic [1:0]  amp;
  logic [1:0]  mode;
  logic        f_act;
  logic [1:0]  f_sel;
  wire         sda  = !((sda_oe && !sda_drive) || sda_pull);
  wire  [19:0] outs = {run, edge_sel, fb_edge, amp, mode, f_act, f_sel};
  int          miscompares = 0;
  int          n_compared  = 0;

  localparam logic [19:0] dflt = {6'h3f, 6'h3f, 1'b1, 2'h2, 2'h2, 1'b0, 2'h0};

  row_t rows [8] = '{
    '{3'h0, 8'h00, {6'h00, 6'h3f, 1'b1, 2'h2, 2'h2, 1'b0, 2'h0}},
    '{3'h0, 8'h81, {6'h21, 6'h3f, 1'b1, 2'h2, 2'h2, 1'b0, 2'h0}},
    '{3'h2, 8'h40, {6'h21, 6'h10, 1'b1, 2'h2, 2'h2, 1'b0, 2'h0}},
    '{3'h1, 8'h01, {6'h21, 6'h10, 1'b1, 2'h1, 2'h2, 1'b0, 2'h0}},
    '{3'h1, 8'h1b, {6'h21, 6'h10, 1'b1, 2'h3, 2'h2, 1'b0, 2'h0}},
    '{3'h1, 8'h3b, {6'h21, 6'h10, 1'b1, 2'h3, 2'h3, 1'b0, 2'h0}},
    '{3'h3, 8'h18, {6'h21, 6'h10, 1'b0, 2'h3, 2'h3, 1'b0, 2'h0}},
    '{3'h3, 8'h39, {6'h21, 6'h10, 1'b1, 2'h3, 2'h3, 1'b1, 2'h3}}
  };

  always #50 clk = !clk;

  // identity values are arbitrary
  clock_buffer_smbus_regs #(
    .silicon_revision_field (4'h9),
    .maker_code_field       (4'hc),
    .device_category        (2'h1),
    .device_identifier      (6'h13)
  ) dut (
    .clk                       (clk),
    .reset_n                   (reset_n),
    .scl                       (scl),
    .sda_in                    (sda),
    .sda_out                   (sda_drive),
    .sda_oe                    (sda_oe),
    .output_enable_n           (output_enable_n),
    .loop_mode_strap           (loop_mode_strap),
    .address_strap             (address_strap),
    .clock_output_pair_run     (run),
    .edge_rate_select          (edge_sel),
    .feedback_edge_rate_select (fb_edge),
    .amplitude                 (amp),
    .loop_mode                 (mode),
    .freq_select_active        (f_act),
    .freq_choice_bits          (f_sel)
  );

  smbus_host_model host (
    .scl      (scl),
    .sda_pull (sda_pull),
    .sda      (sda)
  );

  // ==========================================================================
  // helpers
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // config reaches the core a few clocks after the ack; bounded wait
  task automatic settle(input logic [19:0] exp);
    // looked at mid cycle, away from the edge that launches the outputs
    for (int i = 0; i < 30 && outs !== exp; i++) @(negedge clk);
    check("core outputs", 32'(outs), 32'(exp));
  endtask

  task automatic do_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (20) @(posedge clk);
  endtask

  task automatic read_check(input logic [7:0] idx, input logic [7:0] exp[$]);
    host.read_block(target_addr, idx, exp.size());
    check("count byte", 32'(host.rd[0]), 32'(exp.size()));
    foreach (exp[k])
      check("read byte", 32'(host.rd[k + 1]), 32'(exp[k]));
  endtask

  // ==========================================================================
  // sequence
  initial begin
    do_reset();
    settle(dflt);
    read_check(8'h00, {8'hdd, 8'h86, 8'hdf, 8'h47, 8'hff, 8'h9c, 8'h53,
                       8'h08});
    foreach (rows[r]) begin
      host.write_block(7'h58, {5'h00, rows[r].idx}, {rows[r].val});
      settle(rows[r].outs);
    end
    @(posedge clk);
    output_enable_n <= 6'h01;
    settle({6'h20, 6'h10, 1'b1, 2'h3, 2'h3, 1'b1, 2'h3});
    // write runs across read-only places into the count register
    host.write_block(7'h58, 8'h03, {8'h00, 8'h00, 8'h00, 8'h00, 8'h03});
    read_check(8'h00, {8'h81, 8'hbf, 8'h42});
    read_check(8'h03, {8'h46, 8'hff, 8'h9c});
    read_check(8'h05, {8'h9c, 8'h53, 8'h03});
    // one data byte more than the count: the surplus byte is refused
    host.start_cond();
    host.put({target_addr, 1'b0});
    host.put(8'h00);
    host.put(8'h01);
    host.put(8'hdd);
    host.put(8'h00);
    host.stop_cond();
    check("missed acks", 32'(host.misses), 32'h1);
    settle({6'h3e, 6'h10, 1'b0, 2'h3, 2'h3, 1'b0, 2'h0});
    host.probe(7'h59);
    check("missed acks", 32'(host.misses), 32'h2);
    // new strap levels are taken only at the next reset
    @(posedge clk);
    loop_mode_strap <= 2'h1;
    address_strap   <= 2'h1;
    target_addr     <= 7'h59;
    do_reset();
    settle({6'h3e, 6'h3f, 1'b1, 2'h2, 2'h1, 1'b0, 2'h0});
    read_check(8'h00, {8'hdd, 8'h46, 8'hdf, 8'h47, 8'hff, 8'h9c, 8'h53,
                       8'h08});
    host.probe(7'h58);
    check("missed acks", 32'(host.misses), 32'h3);
    wrap_up();
  end

endmodule

`default_nettype wire
